// ===== pkg/pin_rail_defines.vh
// Offsets, field positions, reset values and codes of the pin and rail bank
`ifndef PIN_RAIL_DEFINES_VH
`define PIN_RAIL_DEFINES_VH

// ==========================================================================
// Register offsets
`define OFS_PIN_DRIVE_LO     8'h3D
`define OFS_PIN_DRIVE_HI     8'h3E
`define OFS_PIN_LEVEL_LO     8'h3F
`define OFS_PIN_LEVEL_HI     8'h40
`define OFS_CONV_GROUP       8'h41
`define OFS_MON_GROUP        8'h43
`define OFS_FAULT_ACTION     8'h44

// ==========================================================================
// Reset values
`define RST_PIN_DRIVE_LO     2'h0
`define RST_PIN_DRIVE_HI     2'h0
`define RST_CONV_GROUP       8'h00
`define RST_MON_GROUP        6'h00
`define RST_FAULT_ACTION     8'h00
`define RST_READ_DATA        8'h00

// ==========================================================================
// Field positions
`define POS_PIN1_DRIVE       0
`define POS_PIN2_DRIVE       1
`define POS_PIN9_DRIVE       0
`define POS_PIN10_DRIVE      1
`define POS_CONVERTER1       0
`define POS_CONVERTER2       2
`define POS_CONVERTER3       4
`define POS_CONVERTER4       6
`define POS_SUPPLY_MON       2
`define POS_MONITOR1         4
`define POS_MONITOR2         6
`define POS_MCU_ACTION       0
`define POS_SOC_ACTION       2
`define POS_OTHER_ACTION     4
`define POS_SEVERE_ACTION    6

// ==========================================================================
// Rail group codes
`define GRP_NONE             2'h0
`define GRP_MCU              2'h1
`define GRP_SOC              2'h2
`define GRP_OTHER            2'h3

// ==========================================================================
// Fault action codes
`define ACT_IMMEDIATE        2'h0
`define ACT_ORDERLY          2'h1
`define ACT_MCU_ERROR        2'h2
`define ACT_SOC_ERROR        2'h3

`endif

// ===== verilog/level_sync.v
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps

module level_sync #(
  parameter WIDTH = 10
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // Levels
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_r;

  // ========================================================================
  // Synchroniser
  // First stage feeds only the second stage, so metastability stays here
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_r <= {WIDTH{1'b0}};
      syncOut  <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule // level_sync

// ===== verilog/pin_level_and_rail_group_regs.v
// Pin drive, pin level and rail group register bank with fault routing
//
// Operation
// - With pins 1 and 2 as outputs, bit 0 drives pin 1 and bit 1 pin 2.
// - Bits 0 and 1 of the high drive register drive pins 9 and 10.
// - Drive bits and group fields take their defaults from a NVM load.
// - The low level register reports pin n in bit n-1 for pins 1 to 8.
// - The high level register at 0x40 reports pins 9 and 10, reset zero.
// - Converters 1 to 4 each hold a two-bit group code in bits 1:0 to 7:6.
// - Supply monitor, monitor one and two hold groups in 3:2, 5:4, 7:6.
// - High drive at 0x3E, converter groups 0x41, monitor groups 0x43.
// - A fault on any rail of a group raises the action chosen for it.
`timescale 1ns/100ps
`include "pin_rail_defines.vh"

module pin_level_and_rail_group_regs (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // Register port from the serial control interface
  input  wire [7:0] regAddr,
  input  wire       regWrEn,
  input  wire [7:0] regWrData,
  input  wire       regRdEn,
  output reg  [7:0] regRdData,
  // Non-volatile defaults
  input  wire       nvmLoad,
  input  wire [1:0] nvmDriveLo,
  input  wire [1:0] nvmDriveHi,
  input  wire [7:0] nvmConvGroup,
  input  wire [5:0] nvmMonGroup,
  input  wire [7:0] nvmFaultAction,
  // Pins: levels in, drive for pins 1, 2, 9, 10 out
  input  wire [9:0] pinIn,
  input  wire [3:0] pinIsOutput,
  output reg  [3:0] pinOut,
  output reg  [3:0] pinOutEn,
  // Rail faults: converters 1 to 4, supply monitor, monitor 1, monitor 2
  input  wire [6:0] railFault,
  output reg  [3:0] faultActionReq
);

  // ========================================================================
  // Storage
  reg  [1:0] driveLo_r;                 // pin1/pin2 drive level
  reg  [1:0] driveHi_r;                 // pin9/pin10 drive level
  reg  [7:0] convGroup_r;
  reg  [5:0] monGroup_r;                // bits 7:2 of the monitor register
  reg  [7:0] faultAction_r;
  wire [9:0] pinLevel;
  reg  [7:0] rdData_nxt;
  reg  [3:0] actReq_nxt;
  reg  [2:0] groupFault;
  wire [7:0] monGroupFull;

  // Decode of a group code against one rail's field
  function inRailGroup;
    input [1:0] field;
    input [1:0] grp;
    begin
      inRailGroup = (field == grp);
    end
  endfunction

  // Field of the fault action register for a given group
  function [1:0] actionOf;
    input [7:0] actReg;
    input [1:0] grp;
    begin
      case (grp)
        `GRP_MCU:   actionOf = actReg[`POS_MCU_ACTION+1:`POS_MCU_ACTION];
        `GRP_SOC:   actionOf = actReg[`POS_SOC_ACTION+1:`POS_SOC_ACTION];
        `GRP_OTHER: actionOf = actReg[`POS_OTHER_ACTION+1:`POS_OTHER_ACTION];
        default:    actionOf = `ACT_IMMEDIATE;
      endcase
    end
  endfunction

  // ========================================================================
  // Pin level synchroniser
  level_sync #(
    .WIDTH (10)
  ) u_level_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (pinIn),
    .syncOut (pinLevel)
  );

  // Monitor fields in register position, reserved bits 1:0 as zero
  assign monGroupFull = {monGroup_r, 2'h0};

  // ========================================================================
  // Writable registers
  // NVM load outranks a host write so boot defaults always land intact
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      driveLo_r     <= `RST_PIN_DRIVE_LO;
      driveHi_r     <= `RST_PIN_DRIVE_HI;
      convGroup_r   <= `RST_CONV_GROUP;
      monGroup_r    <= `RST_MON_GROUP;
      faultAction_r <= `RST_FAULT_ACTION;
    end else if (nvmLoad) begin
      driveLo_r     <= nvmDriveLo;
      driveHi_r     <= nvmDriveHi;
      convGroup_r   <= nvmConvGroup;
      monGroup_r    <= nvmMonGroup;
      faultAction_r <= nvmFaultAction;
    end else if (regWrEn) begin
      case (regAddr)
        `OFS_PIN_DRIVE_LO: begin
          driveLo_r <= regWrData[1:0];
        end
        `OFS_PIN_DRIVE_HI: begin
          driveHi_r <= regWrData[1:0];
        end
        `OFS_CONV_GROUP: begin
          convGroup_r <= regWrData;
        end
        `OFS_MON_GROUP: begin
          monGroup_r <= regWrData[7:2];
        end
        `OFS_FAULT_ACTION: begin
          faultAction_r <= regWrData;
        end
        default: begin
          driveLo_r <= driveLo_r;           // Level registers ignore writes
        end
      endcase
    end
  end

  // ========================================================================
  // Read mux
  // Unmapped offsets read zero rather than stale data
  always @* begin
    rdData_nxt = 8'h00;
    case (regAddr)
      `OFS_PIN_DRIVE_LO: rdData_nxt = {6'h00, driveLo_r};
      `OFS_PIN_DRIVE_HI: rdData_nxt = {6'h00, driveHi_r};
      `OFS_PIN_LEVEL_LO: rdData_nxt = pinLevel[7:0];
      `OFS_PIN_LEVEL_HI: rdData_nxt = {6'h00, pinLevel[9:8]};
      `OFS_CONV_GROUP:   rdData_nxt = convGroup_r;
      `OFS_MON_GROUP:    rdData_nxt = monGroupFull;
      `OFS_FAULT_ACTION: rdData_nxt = faultAction_r;
      default:           rdData_nxt = 8'h00;
    endcase
  end

  // Read data held until the next read
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= `RST_READ_DATA;
    end else if (regRdEn) begin
      regRdData <= rdData_nxt;
    end
  end

  // ========================================================================
  // Pin drive outputs, bit order pin1, pin2, pin9, pin10
  // Enable follows pin configuration; level always reflects the drive bit
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut   <= 4'h0;
      pinOutEn <= 4'h0;
    end else begin
      pinOut[0] <= driveLo_r[`POS_PIN1_DRIVE];
      pinOut[1] <= driveLo_r[`POS_PIN2_DRIVE];
      pinOut[2] <= driveHi_r[`POS_PIN9_DRIVE];
      pinOut[3] <= driveHi_r[`POS_PIN10_DRIVE];
      pinOutEn  <= pinIsOutput;
    end
  end

  // ========================================================================
  // Group fault detection
  // Index 0 = MCU, 1 = SOC, 2 = OTHER; rails with no group never count
  always @* begin : grp_detect
    integer g;
    reg [1:0] code;
    g          = 0;
    code       = 2'h0;
    groupFault = 3'h0;
    for (g = 0; g < 3; g = g + 1) begin
      code = g[1:0] + 2'h1;
      groupFault[g] =
        (railFault[0] && inRailGroup(convGroup_r[1:0], code)) ||
        (railFault[1] && inRailGroup(convGroup_r[3:2], code)) ||
        (railFault[2] && inRailGroup(convGroup_r[5:4], code)) ||
        (railFault[3] && inRailGroup(convGroup_r[7:6], code)) ||
        (railFault[4] && inRailGroup(monGroupFull[3:2], code)) ||
        (railFault[5] && inRailGroup(monGroupFull[5:4], code)) ||
        (railFault[6] && inRailGroup(monGroupFull[7:6], code));
    end
  end

  // Action request per action code, several may be raised at once
  always @* begin : act_route
    integer g;
    reg [1:0] code;
    reg [1:0] act;
    g          = 0;
    code       = 2'h0;
    act        = 2'h0;
    actReq_nxt = 4'h0;
    for (g = 0; g < 3; g = g + 1) begin
      code = g[1:0] + 2'h1;
      act  = actionOf(faultAction_r, code);
      if (groupFault[g]) begin
        actReq_nxt[act] = 1'b1;
      end
    end
  end

  // Registered request level, one clock behind the fault
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      faultActionReq <= 4'h0;
    end else begin
      faultActionReq <= actReq_nxt;
    end
  end

endmodule // pin_level_and_rail_group_regs

// ===== verif/pin_level_and_rail_group_regs_checker.sv
// Port assertions for the pin and rail group register bank
`timescale 1ns/100ps
module pin_level_and_rail_group_regs_checker (
  // Clock and reset
  input wire       clk,
  input wire       rst_b,
  // Register port
  input wire [7:0] regAddr,
  input wire       regWrEn,
  input wire [7:0] regWrData,
  input wire       regRdEn,
  input wire [7:0] regRdData,
  // Defaults, pins and faults
  input wire       nvmLoad,
  input wire [1:0] nvmDriveLo,
  input wire [1:0] nvmDriveHi,
  input wire [9:0] pinIn,
  input wire [3:0] pinOut,
  input wire [6:0] railFault,
  input wire [3:0] faultActionReq
);
  // ==========
  // Decoded accesses; a write colliding with a load is lost
  wire       wrOk   = regWrEn && !nvmLoad;
  wire [7:0] pinLo  = pinIn[7:0];
  wire [7:0] pinHi  = {6'h00, pinIn[9:8]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========
  // Drive bits reach the pins one cycle after the register
  property p_driveLo;
    wrOk && regAddr == 8'h3D |=> ##1 pinOut[1:0] == $past(regWrData[1:0], 2);
  endproperty
  a_driveLo: assert property (p_driveLo)
    else $error("pin 1/2 drive wrong");
  property p_driveHi;
    wrOk && regAddr == 8'h3E |=> ##1 pinOut[3:2] == $past(regWrData[1:0], 2);
  endproperty
  a_driveHi: assert property (p_driveHi)
    else $error("pin 9/10 drive wrong");
  property p_nvmDrive;
    nvmLoad |=> ##1 pinOut == $past({nvmDriveHi, nvmDriveLo}, 2);
  endproperty
  a_nvmDrive: assert property (p_nvmDrive)
    else $error("loaded drive bits wrong");
  // Levels pass two flops, the read adds one
  property p_levelLo;
    regRdEn && regAddr == 8'h3F |=> regRdData == $past(pinLo, 3);
  endproperty
  a_levelLo: assert property (p_levelLo)
    else $error("low level read wrong");
  property p_levelHi;
    regRdEn && regAddr == 8'h40 |=> regRdData == $past(pinHi, 3);
  endproperty
  a_levelHi: assert property (p_levelHi)
    else $error("high level read wrong");
  // Group fields read back as written, monitor bits 1:0 as zero
  property p_convBack;
    wrOk && regAddr == 8'h41 ##1 !regWrEn && !nvmLoad
      ##1 regRdEn && regAddr == 8'h41
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_convBack: assert property (p_convBack)
    else $error("converter groups wrong");
  property p_monBack;
    wrOk && regAddr == 8'h43 ##1 !regWrEn && !nvmLoad
      ##1 regRdEn && regAddr == 8'h43
      |=> regRdData == ($past(regWrData, 3) & 8'hFC);
  endproperty
  a_monBack: assert property (p_monBack)
    else $error("monitor groups wrong");
  property p_faultIdle;
    railFault == 7'h00 |=> faultActionReq == 4'h0;
  endproperty
  a_faultIdle: assert property (p_faultIdle)
    else $error("fault request without fault");
  property p_unmapped;
    regRdEn && regAddr == 8'h42 |=> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule // pin_level_and_rail_group_regs_checker

bind pin_level_and_rail_group_regs pin_level_and_rail_group_regs_checker
  checker_inst (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
  .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
  .regRdData(regRdData), .nvmLoad(nvmLoad), .nvmDriveLo(nvmDriveLo),
  .nvmDriveHi(nvmDriveHi), .pinIn(pinIn), .pinOut(pinOut),
  .railFault(railFault), .faultActionReq(faultActionReq));

// ===== verif/pin_level_and_rail_group_regs_bench.sv
// Self-checking bench for the pin and rail group register bank
`timescale 1ns/100ps
module pin_level_and_rail_group_regs_bench;
  // ==========
  // Stimulus and observed signals
  logic       clk = 0, rst_b = 0, regWrEn = 0, regRdEn = 0, nvmLoad = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [7:0] nvmConvGroup = 8'h00, nvmFaultAction = 8'h00;
  logic [1:0] nvmDriveLo = 2'h0, nvmDriveHi = 2'h0;
  logic [5:0] nvmMonGroup = 6'h00;
  logic [9:0] pinIn = 10'h000;
  logic [3:0] pinIsOutput = 4'h0, pinOut, pinOutEn, faultActionReq;
  logic [6:0] railFault = 7'h00;
  logic [7:0] ofs [8] = '{8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42,
                          8'h43, 8'h44};
  int         errors = 0, checked = 0;
  pin_level_and_rail_group_regs pin_level_and_rail_group_regs_inst (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .nvmLoad(nvmLoad), .nvmDriveLo(nvmDriveLo), .nvmDriveHi(nvmDriveHi),
    .nvmConvGroup(nvmConvGroup), .nvmMonGroup(nvmMonGroup),
    .nvmFaultAction(nvmFaultAction), .pinIn(pinIn),
    .pinIsOutput(pinIsOutput), .pinOut(pinOut), .pinOutEn(pinOutEn),
    .railFault(railFault), .faultActionReq(faultActionReq));
  initial forever #10 clk = ~clk;
  // ==========
  // Access tasks; strobes last exactly one edge
  task chk(string n, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 chk($sformatf("reg %h", a), regRdData, e);
  endtask
  task complete_run;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard at 5000 cycles, far beyond the roughly 130 cycles needed
  initial begin
    #100000;
    errors++;
    complete_run;
  end
  // ==========
  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    chk("pinOut", {4'h0, pinOut}, 8'h00);
    chk("pinOutEn", {4'h0, pinOutEn}, 8'h00);
    $display("test reset done");
    @(posedge clk) pinIsOutput <= 4'hF;
    wr(8'h3D, 8'hFE);
    wr(8'h3E, 8'hFD);
    rd(8'h3D, 8'h02);
    rd(8'h3E, 8'h01);
    chk("pinOut", {4'h0, pinOut}, 8'h06);
    chk("pinOutEn", {4'h0, pinOutEn}, 8'h0F);
    for (int g = 0; g < 4; g++) begin
      wr(8'h41, {4{g[1:0]}});
      rd(8'h41, {4{g[1:0]}});
      wr(8'h43, {4{g[1:0]}});
      rd(8'h43, {{3{g[1:0]}}, 2'b00});
    end
    wr(8'h3F, 8'hFF);
    wr(8'h40, 8'hFF);
    rd(8'h3F, 8'h00);
    rd(8'h40, 8'h00);
    $display("test registers done");
    @(posedge clk) pinIn <= 10'h2A5;
    repeat (3) @(posedge clk);
    rd(8'h3F, 8'hA5);
    rd(8'h40, 8'h02);
    $display("test levels done");
    // Load wins over a host write in the same cycle
    @(posedge clk);
    {nvmDriveHi, nvmDriveLo, nvmMonGroup} <= {2'h2, 2'h1, 6'h2D};
    {nvmConvGroup, nvmFaultAction} <= {8'h9C, 8'h5A};
    {nvmLoad, regWrEn, regAddr, regWrData} <= {2'b11, 8'h41, 8'h00};
    @(posedge clk);
    {nvmLoad, regWrEn} <= 2'b00;
    rd(8'h3D, 8'h01);
    rd(8'h3E, 8'h02);
    rd(8'h41, 8'h9C);
    rd(8'h43, 8'hB4);
    rd(8'h44, 8'h5A);
    chk("pinOut", {4'h0, pinOut}, 8'h09);
    $display("test load done");
    wr(8'h44, 8'hE4);
    wr(8'h41, 8'h39);
    wr(8'h43, 8'h00);
    rd(8'h44, 8'hE4);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) railFault <= 7'h01 << i;
      @(posedge clk) #1 chk("req", faultActionReq, (8'h01 << i) & 8'h07);
    end
    @(posedge clk) railFault <= 7'h00;
    // Monitor rails, reaching action code 3, which the converters left out
    wr(8'h44, 8'h1B);
    wr(8'h43, 8'hE4);
    rd(8'h43, 8'hE4);
    for (int i = 4; i < 7; i++) begin
      @(posedge clk) railFault <= 7'h01 << i;
      @(posedge clk) #1 chk("req", faultActionReq, 8'h10 >> (i - 3));
    end
    // Several groups at once raise several requests
    @(posedge clk) railFault <= 7'h70;
    @(posedge clk) #1 chk("req", faultActionReq, 8'h0E);
    @(posedge clk) railFault <= 7'h00;
    $display("test faults done");
    complete_run;
  end
endmodule // pin_level_and_rail_group_regs_bench
